//--- rtl/pcams_mode_dec.v
// Decoder from a channel mode byte to its operating mode
`timescale 1ns/1ps
`default_nettype none
`include "pcams_regs.vh"
module pcams_mode_dec
(
  input wire [7:0] mode_i,
  output reg cap_rise_o,
  output reg cap_fall_o,
  output reg sw_timer_o,
  output reg toggle_o,
  output reg freq_o,
  output reg pwm_n_o,
  output reg pwm16_o
);
  wire [4:0] sel = mode_i[5:1];
  always @*
  begin
    cap_rise_o = 1'b0;
    cap_fall_o = 1'b0;
    sw_timer_o = 1'b0;
    toggle_o = 1'b0;
    freq_o = 1'b0;
    pwm_n_o = 1'b0;
    pwm16_o = 1'b0;
    // Only bits named by a mode take part; bit 0 and cfg don't-cares are never looked at
    casez (sel)
      5'b10000: cap_rise_o = 1'b1;
      5'b01000: cap_fall_o = 1'b1;
      5'b11000:
      begin
        cap_rise_o = 1'b1;
        cap_fall_o = 1'b1;
      end
      5'b00100: sw_timer_o = 1'b1;
      5'b00110: toggle_o = 1'b1;
      5'b00011: freq_o = 1'b1;
      5'b00?01:
      begin
        // Bit 7 picks 16-bit over cycle-length PWM
        pwm16_o = mode_i[`PCAMS_M_PWM16];
        pwm_n_o = ~mode_i[`PCAMS_M_PWM16];
      end
      default: ;
    endcase
  end
endmodule // pcams_mode_dec
`default_nettype wire

//--- rtl/pcams_regs.vh
// Register offsets, field positions and reset values for the channel mode select block
`ifndef PCAMS_REGS_VH
`define PCAMS_REGS_VH
`define PCAMS_ADDR_W 4
`define PCAMS_CH0_MODE 4'h0
`define PCAMS_CH1_MODE 4'h1
`define PCAMS_CH2_MODE 4'h2
`define PCAMS_PWM_CFG 4'h3
`define PCAMS_CH0_CMPL 4'h4
`define PCAMS_CH0_CMPH 4'h5
`define PCAMS_CH1_CMPL 4'h6
`define PCAMS_CH1_CMPH 4'h7
`define PCAMS_CH2_CMPL 4'h8
`define PCAMS_CH2_CMPH 4'h9
`define PCAMS_EVT_FLAGS 4'hA
`define PCAMS_MODE_RST 8'h00
`define PCAMS_CFG_RST 8'h00
`define PCAMS_M_IRQEN 0
`define PCAMS_M_PWM 1
`define PCAMS_M_TOG 2
`define PCAMS_M_MAT 3
`define PCAMS_M_CAPN 4
`define PCAMS_M_CAPP 5
`define PCAMS_M_CMPEN 6
`define PCAMS_M_PWM16 7
`define PCAMS_C_CYCLE_LENGTH_SELECT_LO 0
`define PCAMS_C_CYCLE_LENGTH_SELECT_HI 1
`define PCAMS_C_OVF_IRQEN 5
`define PCAMS_C_OVF_FLAG 6
`define PCAMS_C_RELOAD 7
`define PCAMS_C_WMASK 8'hA3
`endif

//--- rtl/pcams_top.v
// Three-channel capture/compare mode select with shared PWM configuration
`timescale 1ns/1ps
`default_nettype none
`include "pcams_regs.vh"
// Function
// - Each channel has its own mode register
// - One cycle length shared by all cycle-length PWM channels
// - Bit 0 gates channel flag onto interrupt
// - Bit 5 only: capture on rising edge
// - Bit 4 only: capture on falling edge
// - Bits 5 and 4: capture either edge
// - Timer, toggle, frequency modes by bits 3-1
// - Bit 1, length 00: 8-bit PWM
// - Lengths 01,10,11 give 9,10,11-bit PWM
// - 16-bit PWM ignores cycle length field
// - Config bit 7 selects reload register view
// - Bit 6 clear: comparator off, PWM low
// - Config bit 5 enables partial overflow interrupt
// - Don't-care bits have no effect
// - PWM match sets flag when bit 3
// - Low byte write clears, high sets enable, except reload-view writes in cycle-length PWM
module pcams_top #(
  parameter NCH = 3
)
(
  input wire core_clk_i,
  input wire srst_i,
  input wire [`PCAMS_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire [15:0] count_i,
  input wire count_tick_i,
  input wire [NCH-1:0] channel_pin_i,
  output reg [NCH-1:0] channel_pin_o,
  output reg [NCH-1:0] channel_event_flag_o,
  output reg [NCH-1:0] channel_irq_o,
  output reg ovf_irq_o
);
  reg [7:0] mode_q [0:NCH-1];
  reg [15:0] cmp_q [0:NCH-1];
  reg [15:0] rld_q [0:NCH-1];
  reg [7:0] cfg_q;
  reg [NCH-1:0] pin_s1_q;
  reg [NCH-1:0] pin_s2_q;
  reg [NCH-1:0] pin_s3_q;
  wire [1:0] cycle_length_select = cfg_q[`PCAMS_C_CYCLE_LENGTH_SELECT_HI:`PCAMS_C_CYCLE_LENGTH_SELECT_LO];
  wire [NCH-1:0] cap_r, cap_f, swt, tog, frq, pwmn, pwm16;

  function [15:0] len_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: len_mask = 16'h00FF;
        2'h1: len_mask = 16'h01FF;
        2'h2: len_mask = 16'h03FF;
        default: len_mask = 16'h07FF;
      endcase
    end
  endfunction

  function is_wr;
    input [`PCAMS_ADDR_W-1:0] a;
    input [`PCAMS_ADDR_W-1:0] target;
    begin
      is_wr = reg_wr_i && (a == target);
    end
  endfunction

  function [`PCAMS_ADDR_W-1:0] cmp_lo;
    input [`PCAMS_ADDR_W-1:0] ch;
    begin
      // Compare bytes pair up from index 4: low at 4+2n, high one above
      cmp_lo = `PCAMS_CH0_CMPL + {ch[`PCAMS_ADDR_W-2:0], 1'b0};
    end
  endfunction

  wire [15:0] lmask = len_mask(cycle_length_select);
  wire [15:0] cnt_m = count_i & lmask;
  // Wrap of the low 8..11 bits marks the partial overflow
  wire part_ovf = count_tick_i && (cnt_m == 16'h0000);
  wire reload_view = cfg_q[`PCAMS_C_RELOAD];

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_dec
      // Decoding is per channel so each acts independently
      pcams_mode_dec u_dec (
        .mode_i(mode_q[g]),
        .cap_rise_o(cap_r[g]),
        .cap_fall_o(cap_f[g]),
        .sw_timer_o(swt[g]),
        .toggle_o(tog[g]),
        .freq_o(frq[g]),
        .pwm_n_o(pwmn[g]),
        .pwm16_o(pwm16[g])
      );
    end
  endgenerate

  integer i;
  integer j;
  reg [NCH-1:0] hit;
  reg [NCH-1:0] evt;
  reg [7:0] rd_d;
  reg [15:0] view;
  always @*
  begin
    hit = {NCH{1'b0}};
    evt = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1)
    begin
      // Comparator only runs with bit 6 set
      if (mode_q[i][`PCAMS_M_CMPEN] && count_tick_i)
      begin
        if (frq[i])
          hit[i] = (count_i[7:0] == cmp_q[i][7:0]);
        else if (pwmn[i])
          hit[i] = (cnt_m == (cmp_q[i] & lmask));
        else
          hit[i] = (count_i == cmp_q[i]);
      end
      if (cap_r[i] && pin_s2_q[i] && !pin_s3_q[i])
        evt[i] = 1'b1;
      if (cap_f[i] && !pin_s2_q[i] && pin_s3_q[i])
        evt[i] = 1'b1;
      if ((swt[i] || tog[i]) && hit[i])
        evt[i] = 1'b1;
      // Match flag in PWM or frequency modes only with bit 3
      if ((pwmn[i] || pwm16[i] || frq[i]) && mode_q[i][`PCAMS_M_MAT] && hit[i])
        evt[i] = 1'b1;
    end
    rd_d = 8'h00;
    view = 16'h0000;
    case (reg_addr_i)
      `PCAMS_CH0_MODE: rd_d = mode_q[0];
      `PCAMS_CH1_MODE: rd_d = mode_q[1];
      `PCAMS_CH2_MODE: rd_d = mode_q[2];
      `PCAMS_PWM_CFG: rd_d = cfg_q;
      `PCAMS_EVT_FLAGS: rd_d = {{(8-NCH){1'b0}}, channel_event_flag_o};
      default:
      begin
        for (i = 0; i < NCH; i = i + 1)
        begin
          view = (reload_view && pwmn[i]) ? rld_q[i] : cmp_q[i];
          if (reg_addr_i == cmp_lo(i[`PCAMS_ADDR_W-1:0]))
            rd_d = view[7:0];
          if (reg_addr_i == cmp_lo(i[`PCAMS_ADDR_W-1:0]) + 4'h1)
            rd_d = view[15:8];
        end
      end
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      for (j = 0; j < NCH; j = j + 1)
      begin
        mode_q[j] <= `PCAMS_MODE_RST;
        cmp_q[j] <= 16'h0000;
        rld_q[j] <= 16'h0000;
      end
      cfg_q <= `PCAMS_CFG_RST;
      pin_s1_q <= {NCH{1'b0}};
      pin_s2_q <= {NCH{1'b0}};
      pin_s3_q <= {NCH{1'b0}};
      reg_rdata_o <= 8'h00;
      channel_pin_o <= {NCH{1'b0}};
      channel_event_flag_o <= {NCH{1'b0}};
      channel_irq_o <= {NCH{1'b0}};
      ovf_irq_o <= 1'b0;
    end
    else
    begin
      pin_s1_q <= channel_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (reg_rd_i)
        reg_rdata_o <= rd_d;
      // One cycle-length field serves every cycle-length PWM channel; 16-bit PWM ignores it
      if (is_wr(reg_addr_i, `PCAMS_PWM_CFG))
        cfg_q <= (cfg_q & ~`PCAMS_C_WMASK) | (reg_wdata_i & `PCAMS_C_WMASK);
      if (part_ovf)
        cfg_q[`PCAMS_C_OVF_FLAG] <= 1'b1;
      else if (is_wr(reg_addr_i, `PCAMS_PWM_CFG) && !reg_wdata_i[`PCAMS_C_OVF_FLAG])
        cfg_q[`PCAMS_C_OVF_FLAG] <= 1'b0;
      ovf_irq_o <= cfg_q[`PCAMS_C_OVF_IRQEN] & cfg_q[`PCAMS_C_OVF_FLAG];
      for (j = 0; j < NCH; j = j + 1)
      begin
        if (is_wr(reg_addr_i, `PCAMS_CH0_MODE + j[`PCAMS_ADDR_W-1:0]))
          mode_q[j] <= reg_wdata_i;
        if (is_wr(reg_addr_i, cmp_lo(j[`PCAMS_ADDR_W-1:0])))
        begin
          if (reload_view && pwmn[j])
            rld_q[j][7:0] <= reg_wdata_i;
          else
          begin
            cmp_q[j][7:0] <= reg_wdata_i;
            mode_q[j][`PCAMS_M_CMPEN] <= 1'b0;
          end
        end
        if (is_wr(reg_addr_i, cmp_lo(j[`PCAMS_ADDR_W-1:0]) + 4'h1))
        begin
          if (reload_view && pwmn[j])
            rld_q[j][15:8] <= reg_wdata_i;
          else
          begin
            cmp_q[j][15:8] <= reg_wdata_i;
            mode_q[j][`PCAMS_M_CMPEN] <= 1'b1;
          end
        end
        if (evt[j] && (cap_r[j] || cap_f[j]))
          cmp_q[j] <= count_i;
        if (frq[j] && hit[j])
          cmp_q[j][7:0] <= cmp_q[j][7:0] + cmp_q[j][15:8];
        // Low counter wrap reloads compare from the high byte or reload register
        if (pwmn[j] && count_tick_i && cnt_m == 16'h0000)
        begin
          if (cycle_length_select == 2'h0)
            cmp_q[j][7:0] <= cmp_q[j][15:8];
          else
            cmp_q[j] <= rld_q[j];
        end
        if (pwm16[j] && count_tick_i && count_i == 16'h0000)
          channel_pin_o[j] <= 1'b0;
        if (tog[j] || frq[j])
        begin
          if (hit[j])
            channel_pin_o[j] <= ~channel_pin_o[j];
        end
        else if (pwmn[j] || pwm16[j])
        begin
          if (!mode_q[j][`PCAMS_M_CMPEN])
            channel_pin_o[j] <= 1'b0;
          else if (hit[j])
            channel_pin_o[j] <= 1'b1;
          else if (count_tick_i && (pwm16[j] ? count_i : cnt_m) == 16'h0000)
            channel_pin_o[j] <= 1'b0;
        end
        // Hardware set beats a software clear in the same cycle
        if (evt[j])
          channel_event_flag_o[j] <= 1'b1;
        else if (is_wr(reg_addr_i, `PCAMS_EVT_FLAGS) && !reg_wdata_i[j])
          channel_event_flag_o[j] <= 1'b0;
        channel_irq_o[j] <= channel_event_flag_o[j] & mode_q[j][`PCAMS_M_IRQEN];
      end
    end
  end
endmodule // pcams_top
`default_nettype wire

//--- tb/pcams_pin_model.sv
// Model of the external source driving the channel pins
`timescale 1ns/1ps
`default_nettype none
module pcams_pin_model
(
  input wire logic core_clk_i,
  input wire logic [2:0] level_i,
  output logic [2:0] pin_o
);
  // Levels move only at the falling edge and then stay for many cycles
  always @(negedge core_clk_i)
  begin
    pin_o <= level_i;
  end
endmodule // pcams_pin_model
`default_nettype wire

//--- tb/pcams_top_sva.sv
// Port assertions for the channel mode select block
`timescale 1ns/1ps
`default_nettype none
`include "pcams_regs.vh"
module pcams_top_sva #(parameter NCH = 3)
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [`PCAMS_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [NCH-1:0] channel_pin_o,
  input wire logic [NCH-1:0] channel_event_flag_o,
  input wire logic [NCH-1:0] channel_irq_o,
  input wire logic ovf_irq_o
);
  logic [7:0] m0_q;
  logic c5_q;
  // Shadow of channel 0 mode byte, including the compare-write side effect
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      m0_q <= 8'h00;
      c5_q <= 1'b0;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `PCAMS_CH0_MODE) m0_q <= reg_wdata_i;
      if (reg_addr_i == `PCAMS_CH0_CMPL) m0_q[6] <= 1'b0;
      if (reg_addr_i == `PCAMS_CH0_CMPH) m0_q[6] <= 1'b1;
      if (reg_addr_i == `PCAMS_PWM_CFG) c5_q <= reg_wdata_i[5];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_irq_follow: assert property (channel_irq_o[0] == $past(channel_event_flag_o[0] && m0_q[0]))
    else $error("channel irq does not follow flag and enable");
  a_flag_sticky: assert property ($past(channel_event_flag_o[0])
    && !$past(reg_wr_i && reg_addr_i == `PCAMS_EVT_FLAGS) |-> channel_event_flag_o[0])
    else $error("event flag dropped without a clear");
  a_rd_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_unmapped_rd: assert property ($past(reg_rd_i && reg_addr_i > `PCAMS_EVT_FLAGS) |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_clear: assert property ($past(srst_i) |-> {channel_pin_o, channel_event_flag_o, channel_irq_o,
    ovf_irq_o, reg_rdata_o} == 0)
    else $error("outputs not cleared by reset");
  a_ovf_gate: assert property (ovf_irq_o |-> $past(c5_q))
    else $error("overflow irq while disabled");
  a_cmp_quiet: assert property (!m0_q[6] && !$past(m0_q[6]) |-> !$rose(channel_pin_o[0]))
    else $error("pin moved with comparator off");
  a_cfg_fixed: assert property ($past(reg_rd_i && reg_addr_i == `PCAMS_PWM_CFG) |-> reg_rdata_o[4:2] == 3'h0)
    else $error("fixed config bits not zero");
  a_mode_rd: assert property ($past(reg_rd_i && reg_addr_i == `PCAMS_CH0_MODE) |-> reg_rdata_o == $past(m0_q))
    else $error("mode read differs from written value");
endmodule // pcams_top_sva
`default_nettype wire

//--- tb/tb_pcams_top.sv
// Directed testbench for the channel mode select block
`timescale 1ns/1ps
`default_nettype none
`include "pcams_regs.vh"
module tb_pcams_top;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [15:0] count_i = 16'h0000;
  logic count_tick_i = 1'b0;
  logic [2:0] level = 3'h0;
  wire [2:0] pin_in;
  wire [7:0] rdata;
  wire [2:0] pin_out;
  wire [2:0] flag;
  wire [2:0] irq;
  wire ovf;
  int num_errors = 0;
  int n_tests = 0;
  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  pcams_pin_model i_pcams_pin_model (.core_clk_i(core_clk_i), .level_i(level), .pin_o(pin_in));
  pcams_top #(.NCH(3)) i_pcams_top (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
    .count_i(count_i), .count_tick_i(count_tick_i), .channel_pin_i(pin_in), .channel_pin_o(pin_out),
    .channel_event_flag_o(flag), .channel_irq_o(irq), .ovf_irq_o(ovf));
  task automatic final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    begin
      n_tests++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // Each access leaves one idle cycle so no strobe is driven twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    begin
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
      @(negedge core_clk_i);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    begin
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge core_clk_i);
      reg_rd_i = 1'b0;
      chk(rdata, e);
      @(negedge core_clk_i);
    end
  endtask
  task automatic cnt(input logic [15:0] v);
    begin
      count_i = v;
      count_tick_i = 1'b1;
      @(negedge core_clk_i);
      count_tick_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
    end
  endtask
  task automatic t_regs;
    begin
      for (int a = 0; a <= 10; a++) rdc(a[3:0], 8'h00);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00);
      wr(`PCAMS_CH1_MODE, 8'h5A);
      rdc(`PCAMS_CH0_MODE, 8'h00);
      rdc(`PCAMS_CH1_MODE, 8'h5A);
      wr(`PCAMS_CH1_MODE, 8'h00);
      wr(`PCAMS_PWM_CFG, 8'hFF);
      rdc(`PCAMS_PWM_CFG, 8'hA3);
      wr(`PCAMS_PWM_CFG, 8'h00);
      $display("registers test done");
    end
  endtask
  task automatic t_capture;
    logic [7:0] md [4] = '{8'h21, 8'h11, 8'h31, 8'h20};
    begin
      count_i = 16'hBEEF;
      for (int i = 0; i < 4; i++)
      begin
        wr(`PCAMS_CH0_MODE, md[i]);
        wr(`PCAMS_EVT_FLAGS, 8'h00);
        level[0] = 1'b1;
        repeat (6) @(negedge core_clk_i);
        chk(flag[0], 16'((4'hD >> i) & 4'h1));
        chk(irq[0], 16'((4'h5 >> i) & 4'h1));
        chk({10'h000, pin_out[2:1], flag[2:1], irq[2:1]}, 16'h0000);
        wr(`PCAMS_EVT_FLAGS, 8'h00);
        level[0] = 1'b0;
        repeat (6) @(negedge core_clk_i);
        chk(flag[0], 16'((4'h6 >> i) & 4'h1));
      end
      rdc(`PCAMS_CH0_CMPH, 8'hBE);
      $display("capture test done");
    end
  endtask
  task automatic t_compare;
    begin
      wr(`PCAMS_CH0_MODE, 8'h49);
      wr(`PCAMS_CH0_CMPL, 8'h34);
      rdc(`PCAMS_CH0_MODE, 8'h09);
      wr(`PCAMS_CH0_CMPH, 8'h12);
      rdc(`PCAMS_CH0_MODE, 8'h49);
      wr(`PCAMS_EVT_FLAGS, 8'h00);
      cnt(16'h1233);
      chk(flag[0], 1'b0);
      cnt(16'h1234);
      chk(flag[0], 1'b1);
      wr(`PCAMS_CH0_MODE, 8'h4C);
      cnt(16'h1234);
      chk(pin_out[0], 1'b1);
      wr(`PCAMS_CH0_MODE, 8'h0C);
      cnt(16'h1234);
      chk(pin_out[0], 1'b1);
      $display("compare test done");
    end
  endtask
  task automatic t_pwm;
    begin
      wr(`PCAMS_CH0_CMPL, 8'h80);
      wr(`PCAMS_CH0_CMPH, 8'h80);
      wr(`PCAMS_CH0_MODE, 8'h42);
      cnt(16'h0100);
      chk(pin_out[0], 1'b0);
      cnt(16'h0080);
      chk(pin_out[0], 1'b1);
      cnt(16'h0100);
      chk(pin_out[0], 1'b0);
      cnt(16'h0180);
      chk(pin_out[0], 1'b1);
      wr(`PCAMS_CH0_MODE, 8'h02);
      cnt(16'h0180);
      chk(pin_out[0], 1'b0);
      wr(`PCAMS_PWM_CFG, 8'h21);
      cnt(16'h02FF);
      cnt(16'h0300);
      chk(ovf, 1'b0);
      cnt(16'h03FF);
      cnt(16'h0400);
      chk(ovf, 1'b1);
      rdc(`PCAMS_PWM_CFG, 8'h61);
      wr(`PCAMS_PWM_CFG, 8'h21);
      rdc(`PCAMS_PWM_CFG, 8'h21);
      wr(`PCAMS_PWM_CFG, 8'h81);
      wr(`PCAMS_CH0_CMPL, 8'h55);
      rdc(`PCAMS_CH0_CMPL, 8'h55);
      wr(`PCAMS_PWM_CFG, 8'h01);
      rdc(`PCAMS_CH0_CMPL, 8'h00);
      wr(`PCAMS_CH0_MODE, 8'hCA);
      wr(`PCAMS_CH0_CMPL, 8'h00);
      wr(`PCAMS_CH0_CMPH, 8'h02);
      wr(`PCAMS_EVT_FLAGS, 8'h00);
      cnt(16'h0200);
      chk(pin_out[0], 1'b1);
      chk(flag[0], 1'b1);
      cnt(16'h0400);
      chk(pin_out[0], 1'b1);
      cnt(16'h0000);
      chk(pin_out[0], 1'b0);
      wr(`PCAMS_PWM_CFG, 8'h00);
      $display("pwm test done");
    end
  endtask
  initial
  begin
    repeat (50000) @(negedge core_clk_i);
    num_errors++;
    final_report();
  end
  initial
  begin
    repeat (20) @(negedge core_clk_i);
    srst_i = 1'b0;
    @(negedge core_clk_i);
    t_regs();
    t_capture();
    t_compare();
    t_pwm();
    final_report();
  end
endmodule // tb_pcams_top
bind pcams_top pcams_top_sva #(.NCH(NCH)) i_pcams_top_sva (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .channel_pin_o(channel_pin_o), .channel_event_flag_o(channel_event_flag_o),
  .channel_irq_o(channel_irq_o), .ovf_irq_o(ovf_irq_o));
`default_nettype wire
